/* File: design/fbp_pkg.sv */
// Shared constants and types for the flash block protection controller
package fbp_pkg;
  // Array geometry
  localparam int FBP_SIZE_BYTES = 131072;
  localparam int FBP_BLOCK_BYTES = 1024;
  localparam int FBP_UNIT_BYTES = 2048;
  localparam int FBP_WORD_BYTES = 4;
  localparam int FBP_DATA_W = 32;
  localparam int FBP_ADDR_W = $clog2(FBP_SIZE_BYTES);
  localparam int FBP_WORDS = FBP_SIZE_BYTES / FBP_WORD_BYTES;
  localparam int FBP_WIDX_W = $clog2(FBP_WORDS);
  localparam int FBP_BLOCKS = FBP_SIZE_BYTES / FBP_BLOCK_BYTES;
  localparam int FBP_BLK_W = $clog2(FBP_BLOCKS);
  localparam int FBP_UNITS = FBP_SIZE_BYTES / FBP_UNIT_BYTES;
  localparam int FBP_UNIT_W = $clog2(FBP_UNITS);
  localparam int FBP_BLK_WORDS = FBP_BLOCK_BYTES / FBP_WORD_BYTES;
  localparam int FBP_CNT_W = $clog2(FBP_BLK_WORDS);
  // Field positions inside a byte address
  localparam int FBP_WIDX_LSB = $clog2(FBP_WORD_BYTES);
  localparam int FBP_BLK_LSB = $clog2(FBP_BLOCK_BYTES);
  localparam int FBP_UNIT_LSB = $clog2(FBP_UNIT_BYTES);
  // Erased cell value and the last word of a block sweep
  localparam logic [FBP_DATA_W-1:0] FBP_ERASED_WORD = 32'hffffffff;
  localparam logic [FBP_CNT_W-1:0] FBP_CNT_LAST = 8'hff;
  // Read clients, one read port each
  localparam int FBP_NPORT = 3;
  localparam logic [1:0] FBP_PORT_FETCH = 2'h0;
  localparam logic [1:0] FBP_PORT_DATA = 2'h1;
  localparam logic [1:0] FBP_PORT_DEBUG = 2'h2;

  typedef enum logic [1:0] {
    FBP_OPEN,
    FBP_RDONLY,
    FBP_EXONLY
  } fbp_prot_t;

  localparam fbp_prot_t FBP_PROT_RESET = FBP_OPEN;

  typedef enum logic {
    FBP_IDLE,
    FBP_ERASE
  } fbp_state_t;
endpackage : fbp_pkg

/* File: design/fbp_guard.sv */
// Protection decision for one access against one unit setting
`timescale 1ns/100ps
module fbp_guard (
  input wire fbp_pkg::fbp_prot_t mode,
  input wire logic [1:0] client,
  input wire logic is_modify,
  output logic allow
);
  import fbp_pkg::*;

  // Pure decode, so each port gets its own verdict, set by mode and client, in the same cycle
  always_comb begin
    case (mode)
      FBP_OPEN: allow = 1'b1;
      FBP_RDONLY: allow = !is_modify;
      FBP_EXONLY: allow = !is_modify && (client == FBP_PORT_FETCH);
      default: allow = 1'b0;
    endcase
  end
endmodule : fbp_guard

/* File: design/fbp_flash_ctrl.sv */
// Flash array with block erase, word program and per-unit access protection
`timescale 1ns/100ps
module fbp_flash_ctrl (
  input wire logic clk,
  input wire logic reset_n,
  // Read ports: 0 fetch, 1 data, 2 debug
  input wire logic [fbp_pkg::FBP_NPORT-1:0] rd_req,
  input wire logic [fbp_pkg::FBP_NPORT-1:0][fbp_pkg::FBP_ADDR_W-1:0] rd_addr,
  output wire logic [fbp_pkg::FBP_NPORT-1:0] rd_valid,
  output wire logic [fbp_pkg::FBP_NPORT-1:0] rd_deny,
  output wire logic [fbp_pkg::FBP_NPORT-1:0][fbp_pkg::FBP_DATA_W-1:0] rd_data,
  // Erase and program requests
  input wire logic erase_req,
  input wire logic [fbp_pkg::FBP_BLK_W-1:0] erase_block,
  input wire logic prog_req,
  input wire logic [fbp_pkg::FBP_ADDR_W-1:0] prog_addr,
  input wire logic [fbp_pkg::FBP_DATA_W-1:0] prog_data,
  output logic busy,
  output logic erase_done,
  output logic prog_done,
  output logic mod_refused,
  // Protection setting per unit
  input wire logic prot_we,
  input wire logic [fbp_pkg::FBP_UNIT_W-1:0] prot_unit,
  input wire fbp_pkg::fbp_prot_t prot_mode,
  output fbp_pkg::fbp_prot_t prot_rd_mode,
  // Sticky violation status
  input wire logic viol_clear,
  output logic viol
);
  import fbp_pkg::*;

  // Nonvolatile cells carry no reset; contents survive system reset
  logic [FBP_DATA_W-1:0] mem [FBP_WORDS];

  fbp_prot_t prot_ff [FBP_UNITS];
  fbp_state_t state_ff;
  fbp_state_t nxt_state;
  logic [FBP_BLK_W-1:0] blk_ff;
  logic [FBP_CNT_W-1:0] cnt_ff;
  logic erase_done_ff;
  logic prog_done_ff;
  logic refused_ff;
  logic viol_ff;
  logic [FBP_NPORT-1:0] rd_deny_now;

  logic idle;
  logic mod_req;
  logic [FBP_UNIT_W-1:0] mod_unit;
  logic mod_allow;
  logic erase_start;
  logic prog_do;
  logic refuse_mod;
  logic [FBP_WIDX_W-1:0] prog_idx;
  logic sweep_last;

  // Modify path: erase wins over program when both arrive together
  assign idle = (state_ff == FBP_IDLE);
  assign mod_req = erase_req || prog_req;
  assign prog_idx = prog_addr[FBP_ADDR_W-1:FBP_WIDX_LSB];
  // A block's unit is its index without the lowest bit
  assign mod_unit = erase_req ? erase_block[FBP_BLK_W-1:FBP_UNIT_LSB-FBP_BLK_LSB]
                              : prog_addr[FBP_ADDR_W-1:FBP_UNIT_LSB];

  fbp_guard u_mod_guard (
    .mode(prot_ff[mod_unit]),
    .client(FBP_PORT_DATA),
    .is_modify(1'b1),
    .allow(mod_allow)
  );

  assign erase_start = idle && erase_req && mod_allow;
  assign prog_do = idle && !erase_req && prog_req && mod_allow;
  assign refuse_mod = idle && mod_req && !mod_allow;
  assign sweep_last = (state_ff == FBP_ERASE) && (cnt_ff == FBP_CNT_LAST);

  // Erase and program requests made while busy are ignored, so the source must watch busy
  assign busy = !idle;

  // Erase sequencer: one word per cycle across the whole block
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      FBP_IDLE: begin
        if (erase_start) begin
          nxt_state = FBP_ERASE;
        end
      end
      FBP_ERASE: begin
        if (sweep_last) begin
          nxt_state = FBP_IDLE;
        end
      end
      default: nxt_state = FBP_IDLE;
    endcase
  end

  // Sequencer state
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= FBP_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Block under erase and word counter
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      blk_ff <= '0;
      cnt_ff <= '0;
    end else if (erase_start) begin
      blk_ff <= erase_block;
      cnt_ff <= '0;
    end else if (state_ff == FBP_ERASE) begin
      cnt_ff <= cnt_ff + FBP_CNT_W'(1);
    end
  end

  // Array writes; program can only clear bits, as a real cell would
  always_ff @(posedge clk) begin
    if (state_ff == FBP_ERASE) begin
      mem[{blk_ff, cnt_ff}] <= FBP_ERASED_WORD;
    end else if (prog_do) begin
      mem[prog_idx] <= mem[prog_idx] & prog_data;
    end
  end

  // Completion and refusal pulses
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      erase_done_ff <= 1'b0;
      prog_done_ff <= 1'b0;
      refused_ff <= 1'b0;
    end else begin
      erase_done_ff <= sweep_last;
      prog_done_ff <= prog_do;
      refused_ff <= refuse_mod;
    end
  end

  assign erase_done = erase_done_ff;
  assign prog_done = prog_done_ff;
  assign mod_refused = refused_ff;

  // Protection table; any unit may be changed at any time
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int u = 0; u < FBP_UNITS; u++) begin
        prot_ff[u] <= FBP_PROT_RESET;
      end
    end else if (prot_we) begin
      prot_ff[prot_unit] <= prot_mode;
    end
  end

  assign prot_rd_mode = prot_ff[prot_unit];

  // One read port per client; a denied read returns zero, never array data
  for (genvar g = 0; g < FBP_NPORT; g++) begin : g_rd
    logic allow;
    logic valid_ff;
    logic deny_ff;
    logic [FBP_DATA_W-1:0] data_ff;
    logic [FBP_UNIT_W-1:0] unit;
    logic [FBP_WIDX_W-1:0] idx;

    assign unit = rd_addr[g][FBP_ADDR_W-1:FBP_UNIT_LSB];
    assign idx = rd_addr[g][FBP_ADDR_W-1:FBP_WIDX_LSB];

    fbp_guard u_rd_guard (
      .mode(prot_ff[unit]),
      .client(2'(g)),
      .is_modify(1'b0),
      .allow(allow)
    );

    assign rd_deny_now[g] = rd_req[g] && !allow;

    // Answer registered one edge after the request
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        valid_ff <= 1'b0;
        deny_ff <= 1'b0;
        data_ff <= '0;
      end else begin
        valid_ff <= rd_req[g];
        deny_ff <= rd_deny_now[g];
        data_ff <= (rd_req[g] && allow) ? mem[idx] : '0;
      end
    end

    assign rd_valid[g] = valid_ff;
    assign rd_deny[g] = deny_ff;
    assign rd_data[g] = data_ff;
  end

  // Sticky violation; a new refusal beats a clear in the same cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      viol_ff <= 1'b0;
    end else if (refuse_mod || (|rd_deny_now)) begin
      viol_ff <= 1'b1;
    end else if (viol_clear) begin
      viol_ff <= 1'b0;
    end
  end

  assign viol = viol_ff;
endmodule : fbp_flash_ctrl

/* File: dv/fbp_monitor.sv */
// Port checker for the flash protection controller
`timescale 1ns/100ps
module fbp_monitor (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [2:0] rd_req,
  input wire logic [2:0] rd_valid,
  input wire logic [2:0] rd_deny,
  input wire logic [2:0][31:0] rd_data,
  input wire logic prog_req,
  input wire logic busy,
  input wire logic erase_done,
  input wire logic prog_done,
  input wire logic mod_refused,
  input wire logic viol_clear,
  input wire logic viol
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Busy cycles of one sweep; 9 bits so a full 256 fits
  logic [8:0] sweep_ff;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) sweep_ff <= 9'h0;
    else sweep_ff <= busy ? sweep_ff + 9'h1 : 9'h0;
  end
  a_read_next_cycle: assert property (rd_req[0] |=> rd_valid[0])
    else $error("fetch read late");
  a_valid_has_cause: assert property (rd_valid[1] |-> $past(rd_req[1]))
    else $error("data answer without request");
  a_deny_hides_data: assert property (rd_deny[2] |-> rd_valid[2] && rd_data[2] == 32'h0)
    else $error("denied debug read leaks data");
  a_deny_sets_viol: assert property (|rd_deny |-> ##[0:1] viol)
    else $error("denied read left flag low");
  a_refuse_sets_viol: assert property (mod_refused |-> ##[0:1] viol)
    else $error("refusal left flag low");
  a_sweep_length: assert property (erase_done |-> sweep_ff == 9'h100)
    else $error("sweep length wrong");
  a_sweep_ends_done: assert property ($fell(busy) |-> erase_done)
    else $error("sweep ended without done");
  a_refuse_no_done: assert property (mod_refused |-> !prog_done && !erase_done)
    else $error("refused request completed");
  a_viol_sticky: assert property (viol && !viol_clear |=> viol)
    else $error("flag dropped by itself");
  // Erase may win the same cycle, so busy also counts as an answer
  a_prog_answered: assert property (prog_req && !busy |=> prog_done || mod_refused || busy)
    else $error("program left unanswered");
  c_erase: cover property (erase_done);
  c_refused: cover property (mod_refused);
  c_deny: cover property (rd_deny[1]);
endmodule : fbp_monitor
bind fbp_flash_ctrl fbp_monitor mon (
  .clk(clk),
  .reset_n(reset_n),
  .rd_req(rd_req),
  .rd_valid(rd_valid),
  .rd_deny(rd_deny),
  .rd_data(rd_data),
  .prog_req(prog_req),
  .busy(busy),
  .erase_done(erase_done),
  .prog_done(prog_done),
  .mod_refused(mod_refused),
  .viol_clear(viol_clear),
  .viol(viol)
);

/* File: dv/fbp_clients.sv */
// Read clients: fetch, data and debugger request paths
`timescale 1ns/100ps
module fbp_clients (
  input wire logic clk,
  input wire logic [2:0] want,
  input wire logic [16:0] where,
  output logic [2:0] req,
  output logic [2:0][16:0] addr
);
  initial begin
    req = 3'h0;
    addr = {3{17'h0}};
  end
  // Idle address lines flip so a stale address never looks live
  always @(negedge clk) begin
    req <= want;
    for (int g = 0; g < 3; g++) addr[g] <= want[g] ? where : ~addr[g];
  end
endmodule : fbp_clients

/* File: dv/flash_block_protection_bench.sv */
// Self-checking bench for the flash protection controller
`timescale 1ns/100ps
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin bad_count++; \
  $display("wrong value %s exp %h got %h", n, e, s); end end
module flash_block_protection_bench;
  import fbp_pkg::*;
  logic clk = 1'b0, reset_n = 1'b0;
  logic [2:0] want, rd_req, rd_valid, rd_deny;
  logic [2:0][16:0] rd_addr;
  logic [2:0][31:0] rd_data;
  logic [16:0] where, pa;
  logic [31:0] pd, p1;
  logic [6:0] blk;
  logic [5:0] pu, u;
  logic erase_req, prog_req, prot_we, viol_clear, busy, erase_done, prog_done, mod_refused, viol;
  fbp_prot_t pm, prot_rd_mode;
  int bad_count = 0, tests_run = 0, n;
  always #20 clk = ~clk;
  fbp_clients cl (.clk(clk), .want(want), .where(where), .req(rd_req), .addr(rd_addr));
  fbp_flash_ctrl DUT (.clk(clk), .reset_n(reset_n), .rd_req(rd_req), .rd_addr(rd_addr),
    .rd_valid(rd_valid), .rd_deny(rd_deny), .rd_data(rd_data), .erase_req(erase_req),
    .erase_block(blk), .prog_req(prog_req), .prog_addr(pa), .prog_data(pd), .busy(busy),
    .erase_done(erase_done), .prog_done(prog_done), .mod_refused(mod_refused),
    .prot_we(prot_we), .prot_unit(pu), .prot_mode(pm), .prot_rd_mode(prot_rd_mode),
    .viol_clear(viol_clear), .viol(viol));
  // Programming only clears bits
  function automatic logic [31:0] prog_exp(input logic [31:0] old, input logic [31:0] d);
    return old & d;
  endfunction : prog_exp
  task automatic conclude;
    if (bad_count == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  // One read on port g; a denied read must carry zero
  task automatic rd(input int g, input logic [16:0] a, input logic dn, input logic [31:0] e);
    @(posedge clk) want = 3'h1 << g;
    where = a;
    @(posedge clk) want = 3'h0;
    @(negedge clk);
    `CHK("rd_valid", 1'b1, rd_valid[g])
    `CHK("rd_deny", dn, rd_deny[g])
    `CHK("rd_data", dn ? 32'h0 : e, rd_data[g])
  endtask : rd
  // Erase (e) or program request; ok says whether it may proceed
  task automatic md(input logic e, input logic ok);
    @(negedge clk) erase_req = e;
    prog_req = !e;
    @(negedge clk) erase_req = 1'b0;
    prog_req = 1'b0;
    `CHK("mod_refused", !ok, mod_refused)
    `CHK("prog_done", ok && !e, prog_done)
    `CHK("busy", ok && e, busy)
    for (n = 0; n < 300 && ok && e && !erase_done; n++) @(negedge clk);
    if (n == 300) begin
      bad_count++;
      conclude();
    end
  endtask : md
  task automatic prot(input logic [5:0] un, input fbp_prot_t m);
    @(negedge clk) prot_we = 1'b1;
    pu = un;
    pm = m;
    @(negedge clk) prot_we = 1'b0;
    `CHK("prot_rd_mode", m, prot_rd_mode)
  endtask : prot
  initial begin
    void'($urandom(32'hd6c5));
    {want, where, erase_req, prog_req, prot_we, viol_clear, pa, pd, pu, blk} = '0;
    pm = FBP_OPEN;
    repeat (8) @(posedge clk);
    @(negedge clk) reset_n = 1'b1;
    u = 6'($urandom);
    blk = {u, 1'b0};
    pa = {u, 1'b0, 8'($urandom), 2'h0};
    md(1'b1, 1'b1);
    rd(0, pa, 1'b0, FBP_ERASED_WORD);
    pd = $urandom;
    p1 = pd;
    md(1'b0, 1'b1);
    pd = $urandom;
    md(1'b0, 1'b1);
    p1 = prog_exp(p1, pd);
    rd(1, pa, 1'b0, p1);
    // Second block of the same unit, last word, first block untouched
    blk = {u, 1'b1};
    md(1'b1, 1'b1);
    rd(2, {u, 1'b1, 10'h3fc}, 1'b0, FBP_ERASED_WORD);
    rd(1, pa, 1'b0, p1);
    prot(u, FBP_RDONLY);
    // Refused requests aim at the programmed word, so any leak would show
    blk = {u, 1'b0};
    md(1'b1, 1'b0);
    pd = ~p1;
    md(1'b0, 1'b0);
    rd(1, pa, 1'b0, p1);
    prot(u, FBP_EXONLY);
    md(1'b0, 1'b0);
    rd(0, pa, 1'b0, p1);
    rd(1, pa, 1'b1, 32'h0);
    rd(2, pa, 1'b1, 32'h0);
    `CHK("viol", 1'b1, viol)
    @(negedge clk) viol_clear = 1'b1;
    @(negedge clk) viol_clear = 1'b0;
    `CHK("viol", 1'b0, viol)
    rd(1, pa, 1'b1, 32'h0);
    // Mid-run reset: table back to open, flag low, cells keep their data
    @(negedge clk) reset_n = 1'b0;
    @(negedge clk) reset_n = 1'b1;
    `CHK("viol", 1'b0, viol)
    `CHK("prot_rd_mode", FBP_OPEN, prot_rd_mode)
    rd(1, pa, 1'b0, p1);
    prot(u, FBP_EXONLY);
    // Neighbour unit stays open while u is locked
    blk = {u ^ 6'h1, 1'b0};
    md(1'b1, 1'b1);
    // Four distinct words, so each expectation starts from an erased cell
    for (int k = 0; k < 4; k++) begin
      pa = {u ^ 6'h1, 1'b0, 6'($urandom), 2'(k), 2'h0};
      pd = $urandom;
      md(1'b0, 1'b1);
      rd(1, pa, 1'b0, prog_exp(FBP_ERASED_WORD, pd));
    end
    conclude();
  end
endmodule : flash_block_protection_bench
